// File: core/split_timer.sv
// Split auto-reload timer: 16-bit or twin 8-bit, with register port and interrupt
//
// Local design decisions: the register addresses and strobed register access.
`timescale 1ns/100ps
`default_nettype none
// Contract
// - The count is 16 bits held as separately accessible low and high byte registers.
// - Bit 3 of the timer control register selects one 16-bit timer (0) or two 8-bit timers (1).
// - Ticks come from the system clock, the system clock over 12, or the external oscillator over 8.
// - The external oscillator is synchronised to the system clock before it is divided by 8.
// - In 16-bit mode a roll from 0xFFFF loads both reload bytes into the counter.
// - Each 16-bit overflow sets the high overflow flag at control bit 7.
// - With the timer interrupt enabled every high overflow (16-bit or split high half) requests an interrupt.
// - With the interrupt enabled and control bit 5 set, a low byte roll from 0xFF also interrupts.
// - In split mode each half reloads from its own reload byte on its own overflow.
// - In split mode the run-control bit gates the high half only.
// - In split mode the low half counts continuously regardless of run control.
// - Each half has a clock-select bit choosing the system clock or the external-select source.
module split_timer
    import split_timer_pkg::*;
(
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic ext_osc,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    output logic irq
);
    reg_req_t req;
    logic [7:0] timer_control_reg;
    logic [1:0] clock_control_reg;
    logic [7:0] count_low_byte;
    logic [7:0] count_high_byte;
    logic [7:0] reload_low_byte;
    logic [7:0] reload_high_byte;
    logic [1:0] irq_status;
    logic [1:0] irq_mask;
    logic ext_meta, ext_sync, ext_prev;
    logic ext_tick, sys_tick;
    logic split_mode_select, run_control, external_clock_select;
    logic low_overflow_irq_enable, timer_irq_enable;
    logic slow_tick;
    tick_pair_t tick;
    logic low_step, high_step, low_wrap, high_wrap;
    logic ovf_high, ovf_low;
    logic [1:0] events;

    assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};
    assign split_mode_select = timer_control_reg[BIT_SPLIT];
    assign run_control = timer_control_reg[BIT_RUN];
    assign external_clock_select = timer_control_reg[BIT_EXT_CLK_SEL];
    assign low_overflow_irq_enable = timer_control_reg[BIT_LOW_IRQ_EN];
    assign timer_irq_enable = timer_control_reg[BIT_TIMER_IRQ_EN];

    // Write decode used by several processes
    function automatic logic wr_hit(input reg_req_t r, input logic [3:0] a);
        return r.wr && (r.addr == a);
    endfunction

    // ------------------------------------------------------------
    // Tick sources
    // ------------------------------------------------------------
    // Oscillator pin passes two flops; edge detect only looks at the second
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            ext_meta <= 1'b0;
            ext_sync <= 1'b0;
            ext_prev <= 1'b0;
        end else if (clk_en) begin
            ext_meta <= ext_osc;
            ext_sync <= ext_meta;
            ext_prev <= ext_sync;
        end
    end

    // Oscillator must be well below core_clk/2 or edges are lost
    tick_divider #(.DIV(EXT_DIV)) u_ext_div (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .step(ext_sync && !ext_prev),
        .tick(ext_tick)
    );

    tick_divider #(.DIV(SYS_DIV)) u_sys_div (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .step(1'b1),
        .tick(sys_tick)
    );

    // Per-half selection between full rate and the slow source
    always_comb begin
        slow_tick = external_clock_select ? ext_tick : sys_tick;
        tick.high = clock_control_reg[BIT_HIGH_CLK_SEL] ? 1'b1 : slow_tick;
        tick.low = clock_control_reg[BIT_LOW_CLK_SEL] ? 1'b1 : slow_tick;
    end

    // ------------------------------------------------------------
    // Count enables and wraps
    // ------------------------------------------------------------
    // In 16-bit mode the whole count shares the low half's source
    always_comb begin
        if (split_mode_select) begin
            low_step = tick.low;
            high_step = tick.high && run_control;
        end else begin
            low_step = tick.low && run_control;
            high_step = low_step && (count_low_byte == 8'hFF);
        end
        low_wrap = low_step && (count_low_byte == 8'hFF);
        high_wrap = high_step && (count_high_byte == 8'hFF);
        ovf_high = split_mode_select ? high_wrap : (low_wrap && high_wrap);
        ovf_low = low_wrap;
    end

    // ------------------------------------------------------------
    // Counter bytes; software writes win over a tick
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            count_low_byte <= RESET_BYTE;
        end else if (clk_en) begin
            if (wr_hit(req, ADDR_COUNT_LOW)) begin
                count_low_byte <= req.wdata;
            end else if (!split_mode_select && ovf_high) begin
                count_low_byte <= reload_low_byte;
            end else if (split_mode_select && low_wrap) begin
                count_low_byte <= reload_low_byte;
            end else if (low_step) begin
                count_low_byte <= count_low_byte + 8'h01;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            count_high_byte <= RESET_BYTE;
        end else if (clk_en) begin
            if (wr_hit(req, ADDR_COUNT_HIGH)) begin
                count_high_byte <= req.wdata;
            end else if (ovf_high) begin
                count_high_byte <= reload_high_byte;
            end else if (high_step) begin
                count_high_byte <= count_high_byte + 8'h01;
            end
        end
    end

    // ------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            reload_low_byte <= RESET_BYTE;
            reload_high_byte <= RESET_BYTE;
            clock_control_reg <= 2'h0;
            irq_mask <= RESET_EVENTS;
        end else if (clk_en) begin
            if (wr_hit(req, ADDR_RELOAD_LOW)) begin
                reload_low_byte <= req.wdata;
            end
            if (wr_hit(req, ADDR_RELOAD_HIGH)) begin
                reload_high_byte <= req.wdata;
            end
            if (wr_hit(req, ADDR_CLOCK_CONTROL)) begin
                clock_control_reg <= req.wdata[1:0];
            end
            if (wr_hit(req, ADDR_IRQ_MASK)) begin
                irq_mask <= req.wdata[1:0];
            end
        end
    end

    // Control flags: software writes, but a same-cycle overflow still sets
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            timer_control_reg <= RESET_BYTE;
        end else if (clk_en) begin
            if (wr_hit(req, ADDR_TIMER_CONTROL)) begin
                timer_control_reg <= req.wdata & 8'hFD;
            end
            if (ovf_high) begin
                timer_control_reg[BIT_HIGH_OVF] <= 1'b1;
            end
            if (ovf_low) begin
                timer_control_reg[BIT_LOW_OVF] <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Interrupt status, mask and output
    // ------------------------------------------------------------
    always_comb begin
        events = RESET_EVENTS;
        events[BIT_EV_HIGH] = timer_irq_enable && ovf_high;
        events[BIT_EV_LOW] = timer_irq_enable && low_overflow_irq_enable && ovf_low;
    end

    // Set wins over write-one-to-clear
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            irq_status <= RESET_EVENTS;
        end else if (clk_en) begin
            irq_status <= (irq_status & ~(wr_hit(req, ADDR_IRQ_STATUS) ? req.wdata[1:0] : 2'h0))
                | events;
        end
    end

    assign irq = |(irq_status & irq_mask);

    // ------------------------------------------------------------
    // Read data, one cycle after the address; the read strobe is not used
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            reg_rdata <= RESET_BYTE;
        end else if (clk_en) begin
            case (req.addr)
                ADDR_TIMER_CONTROL: reg_rdata <= timer_control_reg;
                ADDR_CLOCK_CONTROL: reg_rdata <= {6'h00, clock_control_reg};
                ADDR_COUNT_LOW: reg_rdata <= count_low_byte;
                ADDR_COUNT_HIGH: reg_rdata <= count_high_byte;
                ADDR_RELOAD_LOW: reg_rdata <= reload_low_byte;
                ADDR_RELOAD_HIGH: reg_rdata <= reload_high_byte;
                ADDR_IRQ_STATUS: reg_rdata <= {6'h00, irq_status};
                ADDR_IRQ_MASK: reg_rdata <= {6'h00, irq_mask};
                default: reg_rdata <= 8'h00;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_wide_reload: assert property (@(posedge core_clk) disable iff (sys_rst)
        clk_en && !split_mode_select && ovf_high && !req.wr
        |=> {count_high_byte, count_low_byte} == $past({reload_high_byte, reload_low_byte}))
        else $error("16-bit overflow did not reload");
    a_high_flag_set: assert property (@(posedge core_clk) disable iff (sys_rst)
        clk_en && ovf_high |=> timer_control_reg[BIT_HIGH_OVF])
        else $error("high overflow flag not set");
    a_flag_sticky: assert property (@(posedge core_clk) disable iff (sys_rst)
        timer_control_reg[BIT_HIGH_OVF] && !req.wr |=> timer_control_reg[BIT_HIGH_OVF])
        else $error("overflow flag dropped without a write");
    a_overflow_irq: assert property (@(posedge core_clk) disable iff (sys_rst)
        clk_en && timer_irq_enable && ovf_high && irq_mask[BIT_EV_HIGH] |=> irq)
        else $error("overflow did not raise interrupt");
    a_low_irq: assert property (@(posedge core_clk) disable iff (sys_rst)
        clk_en && ovf_low && !(timer_irq_enable && low_overflow_irq_enable)
        && !ovf_high && !irq_status[BIT_EV_LOW] |=> !irq_status[BIT_EV_LOW])
        else $error("low interrupt raised while disabled");
    a_split_low_run: assert property (@(posedge core_clk) disable iff (sys_rst)
        clk_en && split_mode_select && tick.low && !req.wr && count_low_byte != 8'hFF
        |=> count_low_byte == $past(count_low_byte) + 8'h01)
        else $error("split low half failed to count");
    a_split_high_gate: assert property (@(posedge core_clk) disable iff (sys_rst)
        clk_en && split_mode_select && !run_control && !req.wr
        |=> count_high_byte == $past(count_high_byte))
        else $error("split high half counted while stopped");
    a_wide_stopped: assert property (@(posedge core_clk) disable iff (sys_rst)
        clk_en && !split_mode_select && !run_control && !req.wr
        |=> $stable(count_low_byte))
        else $error("16-bit counter ran while stopped");
    a_slow_tick: assert property (@(posedge core_clk) disable iff (sys_rst)
        clk_en && sys_tick |=> !sys_tick)
        else $error("divided system tick longer than one cycle");

    // Split mode reloads each half from its own reload byte
    a_split_low_reload: assert property (@(posedge core_clk) disable iff (sys_rst)
        clk_en && split_mode_select && low_wrap && !req.wr
        |=> count_low_byte == $past(reload_low_byte))
        else $error("split low half did not reload");
    a_split_high_reload: assert property (@(posedge core_clk) disable iff (sys_rst)
        clk_en && split_mode_select && ovf_high && !req.wr
        |=> count_high_byte == $past(reload_high_byte))
        else $error("split high half did not reload");

    // Low byte roll carries into the high byte in 16-bit mode
    a_wide_carry: assert property (@(posedge core_clk) disable iff (sys_rst)
        clk_en && !split_mode_select && low_wrap && count_high_byte != 8'hFF && !req.wr
        |=> count_low_byte == 8'h00 && count_high_byte == $past(count_high_byte) + 8'h01)
        else $error("16-bit carry into high byte lost");
    a_wide_high_stopped: assert property (@(posedge core_clk) disable iff (sys_rst)
        clk_en && !split_mode_select && !run_control && !req.wr
        |=> $stable(count_high_byte))
        else $error("16-bit high byte ran while stopped");

    // Low flag, low event, and the write-one-to-clear path
    a_low_flag_set: assert property (@(posedge core_clk) disable iff (sys_rst)
        clk_en && ovf_low |=> timer_control_reg[BIT_LOW_OVF])
        else $error("low overflow flag not set");
    a_low_event: assert property (@(posedge core_clk) disable iff (sys_rst)
        clk_en && timer_irq_enable && low_overflow_irq_enable && ovf_low
        |=> irq_status[BIT_EV_LOW])
        else $error("enabled low overflow left no event");
    a_status_clear: assert property (@(posedge core_clk) disable iff (sys_rst)
        clk_en && wr_hit(req, ADDR_IRQ_STATUS) && req.wdata[BIT_EV_HIGH] && !events[BIT_EV_HIGH]
        |=> !irq_status[BIT_EV_HIGH])
        else $error("high event survived its clear");

    // Cycles since the last slow tick; starts at minus one so the first
    // period after reset reads like every later one
    logic [3:0] since_tick;
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            since_tick <= '1;
        end else if (clk_en) begin
            since_tick <= sys_tick ? 4'h0 : since_tick + 4'h1;
        end
    end

    // The helper above is only four bits wide
    if (SYS_DIV > 16) begin : g_helper_fits
        $error("slow tick helper too narrow for SYS_DIV");
    end

    // Synchroniser stage and slow tick spacing
    a_sync_stage: assert property (@(posedge core_clk) disable iff (sys_rst)
        clk_en |=> ext_sync == $past(ext_meta))
        else $error("oscillator synchroniser skipped a stage");
    a_tick_period: assert property (@(posedge core_clk) disable iff (sys_rst)
        sys_tick |-> since_tick == 4'(SYS_DIV - 1))
        else $error("divided system tick off its period");

    // Clock enable low holds every piece of state
    a_enable_freeze: assert property (@(posedge core_clk) disable iff (sys_rst)
        !clk_en |=> $stable(count_low_byte) && $stable(count_high_byte)
        && $stable(timer_control_reg) && $stable(irq_status))
        else $error("state moved while clock enable was low");

    // Main scenarios
    c_wide_ovf: cover property (@(posedge core_clk) !split_mode_select && ovf_high);
    c_split_both: cover property (@(posedge core_clk) split_mode_select && ovf_low ##1 ovf_high);
    c_ext_tick: cover property (@(posedge core_clk) external_clock_select && ext_tick);
    c_irq: cover property (@(posedge core_clk) irq);
    c_enable_freeze: cover property (@(posedge core_clk) !clk_en && run_control);
endmodule
`default_nettype wire

// File: shared/split_timer_pkg.sv
// Package: register map, field positions, reset values and timing for the split timer
package split_timer_pkg;
    // ------------------------------------------------------------
    // Register offsets (plain register port, byte addresses)
    // ------------------------------------------------------------
    localparam logic [3:0] ADDR_TIMER_CONTROL = 4'h0;
    localparam logic [3:0] ADDR_CLOCK_CONTROL = 4'h1;
    localparam logic [3:0] ADDR_COUNT_LOW = 4'h2;
    localparam logic [3:0] ADDR_COUNT_HIGH = 4'h3;
    localparam logic [3:0] ADDR_RELOAD_LOW = 4'h4;
    localparam logic [3:0] ADDR_RELOAD_HIGH = 4'h5;
    localparam logic [3:0] ADDR_IRQ_STATUS = 4'h6;
    localparam logic [3:0] ADDR_IRQ_MASK = 4'h7;
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int BIT_HIGH_OVF = 7;
    localparam int BIT_LOW_OVF = 6;
    localparam int BIT_LOW_IRQ_EN = 5;
    localparam int BIT_TIMER_IRQ_EN = 4;
    localparam int BIT_SPLIT = 3;
    localparam int BIT_RUN = 2;
    localparam int BIT_EXT_CLK_SEL = 0;
    localparam int BIT_HIGH_CLK_SEL = 1;
    localparam int BIT_LOW_CLK_SEL = 0;
    localparam int BIT_EV_HIGH = 1;
    localparam int BIT_EV_LOW = 0;
    // ------------------------------------------------------------
    // Reset values and timing
    // ------------------------------------------------------------
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [1:0] RESET_EVENTS = 2'h0;
    localparam int SYS_DIV = 12;
    localparam int EXT_DIV = 8;
    localparam int CLK_PERIOD_NS = 25;
    localparam int COUNT_WIDTH = 16;

    // Register port request carried as one bundle
    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

    // Tick sources of both halves
    typedef struct packed {
        logic high;
        logic low;
    } tick_pair_t;
endpackage

// File: core/tick_divider.sv
// Tick divider: one-cycle tick every DIV enabled input events
`timescale 1ns/100ps
`default_nettype none
module tick_divider
    import split_timer_pkg::*;
#(
    parameter int DIV = 12
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic step,
    output logic tick
);
    localparam int W = $clog2(DIV);
    localparam logic [W-1:0] LAST = W'(DIV - 1);
    logic [W-1:0] count;

    // Elaboration check: a divide by one would leave a zero-width counter
    if (DIV < 2) begin : g_div_check
        $error("tick_divider needs DIV of at least 2");
    end

    // ------------------------------------------------------------
    // Counter wraps at DIV-1 and pulses once per wrap
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            count <= '0;
            tick <= 1'b0;
        end else if (clk_en) begin
            tick <= step && (count == LAST);
            if (step) begin
                count <= (count == LAST) ? '0 : count + 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// File: dv/autoreload_timer_split_mode_bench.sv
// Self-checking bench for the split auto-reload timer
`timescale 1ns/100ps
`default_nettype none
module autoreload_timer_split_mode_bench;
    import split_timer_pkg::*;
    logic core_clk;
    logic sys_rst;
    logic clk_en;
    logic ext_osc;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [7:0] reg_rdata;
    logic irq;
    logic [7:0] rd_val;
    int n_fail;
    int tests_run;

    split_timer DUT (.core_clk(core_clk), .sys_rst(sys_rst), .clk_en(clk_en),
        .ext_osc(ext_osc), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));

    // ------------------------------------------------------------
    // Clock, verdict and watchdog
    // ------------------------------------------------------------
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    task automatic wrap_up;
        if (n_fail == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Whole run is about 700 cycles, so nearly thirty times that means a hang
    initial begin
        repeat (20000) @(posedge core_clk);
        n_fail++;
        wrap_up();
    end

    // ------------------------------------------------------------
    // Register port tasks and comparisons
    // ------------------------------------------------------------
    // Strobe raised after one edge, dropped after the edge that takes it
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask

    // Read data stands from the cycle after the taking edge while the address is held
    task automatic rd_reg(input logic [3:0] a);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        rd_val = reg_rdata;
    endtask

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic rd_eq(input string what, input logic [3:0] a, input logic [7:0] exp);
        rd_reg(a);
        chk(what, exp, rd_val);
    endtask

    // Tick latency is a cycle or two, so counts are judged in a window
    task automatic rd_in(input string what, input logic [3:0] a, input logic [7:0] lo,
        input logic [7:0] hi);
        rd_reg(a);
        tests_run++;
        if ($isunknown(rd_val) || rd_val < lo || rd_val > hi) begin
            n_fail++;
            $display("Error %s expected %h..%h seen %h", what, lo, hi, rd_val);
        end
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge core_clk);
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        n_fail = 0;
        tests_run = 0;
        sys_rst = 1'b1;
        clk_en = 1'b1;
        ext_osc = 1'b0;
        reg_addr = 4'h0;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        idle(8);
        sys_rst <= 1'b0;
        // Reset values, unmapped address 8 included
        for (int i = 0; i < 9; i++) begin
            rd_eq("reset value", 4'(i), 8'h00);
        end
        chk("irq after reset", 8'h00, {7'h00, irq});
        // Byte access, reserved bit, unmapped write
        wr_reg(ADDR_RELOAD_LOW, 8'hA5);
        wr_reg(ADDR_RELOAD_HIGH, 8'h5A);
        wr_reg(ADDR_COUNT_LOW, 8'h3C);
        wr_reg(ADDR_COUNT_HIGH, 8'hC3);
        wr_reg(ADDR_TIMER_CONTROL, 8'h02);
        wr_reg(4'h9, 8'hFF);
        rd_eq("reload low", ADDR_RELOAD_LOW, 8'hA5);
        rd_eq("reload high", ADDR_RELOAD_HIGH, 8'h5A);
        rd_eq("reserved bit", ADDR_TIMER_CONTROL, 8'h00);
        rd_eq("unmapped", 4'h9, 8'h00);
        idle(20);
        rd_eq("stopped low", ADDR_COUNT_LOW, 8'h3C);
        rd_eq("stopped high", ADDR_COUNT_HIGH, 8'hC3);
        // 16-bit roll from FFFF on the system clock, both interrupt kinds
        wr_reg(ADDR_CLOCK_CONTROL, 8'h03);
        wr_reg(ADDR_RELOAD_LOW, 8'h00);
        wr_reg(ADDR_RELOAD_HIGH, 8'hFF);
        wr_reg(ADDR_COUNT_LOW, 8'hF0);
        wr_reg(ADDR_COUNT_HIGH, 8'hFF);
        wr_reg(ADDR_IRQ_MASK, 8'h03);
        wr_reg(ADDR_TIMER_CONTROL, 8'h34);
        idle(40);
        rd_eq("16-bit flags", ADDR_TIMER_CONTROL, 8'hF4);
        // Flags written back as ones so the stop keeps them
        wr_reg(ADDR_TIMER_CONTROL, 8'hF0);
        rd_eq("reload high loaded", ADDR_COUNT_HIGH, 8'hFF);
        rd_in("reload low loaded", ADDR_COUNT_LOW, 8'h00, 8'h3F);
        rd_eq("flags sticky", ADDR_TIMER_CONTROL, 8'hF0);
        rd_eq("both events", ADDR_IRQ_STATUS, 8'h03);
        chk("irq raised", 8'h01, {7'h00, irq});
        wr_reg(ADDR_IRQ_MASK, 8'h01);
        wr_reg(ADDR_IRQ_STATUS, 8'h01);
        idle(1);
        chk("irq masked", 8'h00, {7'h00, irq});
        rd_eq("one cleared", ADDR_IRQ_STATUS, 8'h02);
        wr_reg(ADDR_IRQ_MASK, 8'h03);
        idle(1);
        chk("irq unmasked", 8'h01, {7'h00, irq});
        wr_reg(ADDR_IRQ_STATUS, 8'h02);
        wr_reg(ADDR_TIMER_CONTROL, 8'h00);
        chk("irq cleared", 8'h00, {7'h00, irq});
        rd_eq("flags cleared", ADDR_TIMER_CONTROL, 8'h00);
        // Split mode: low half free running, high half held by run control
        wr_reg(ADDR_RELOAD_LOW, 8'hF0);
        wr_reg(ADDR_COUNT_LOW, 8'hF8);
        wr_reg(ADDR_RELOAD_HIGH, 8'h80);
        wr_reg(ADDR_COUNT_HIGH, 8'hFE);
        wr_reg(ADDR_TIMER_CONTROL, 8'h18);
        idle(50);
        rd_eq("high half held", ADDR_COUNT_HIGH, 8'hFE);
        rd_in("low half reloads", ADDR_COUNT_LOW, 8'hF0, 8'hFF);
        rd_eq("split low flag", ADDR_TIMER_CONTROL, 8'h58);
        rd_eq("no low event", ADDR_IRQ_STATUS, 8'h00);
        wr_reg(ADDR_TIMER_CONTROL, 8'h1C);
        idle(30);
        rd_eq("split high flag", ADDR_TIMER_CONTROL, 8'hDC);
        wr_reg(ADDR_TIMER_CONTROL, 8'h08);
        rd_in("high half reloads", ADDR_COUNT_HIGH, 8'h80, 8'hA0);
        rd_eq("split event", ADDR_IRQ_STATUS, 8'h02);
        wr_reg(ADDR_IRQ_STATUS, 8'h03);
        // High half on the slow source while low stays on the system clock
        wr_reg(ADDR_CLOCK_CONTROL, 8'h01);
        wr_reg(ADDR_COUNT_HIGH, 8'h00);
        wr_reg(ADDR_TIMER_CONTROL, 8'h0C);
        idle(60);
        wr_reg(ADDR_TIMER_CONTROL, 8'h08);
        rd_in("high half slow", ADDR_COUNT_HIGH, 8'h05, 8'h06);
        // 16-bit on the system clock over 12
        wr_reg(ADDR_TIMER_CONTROL, 8'h00);
        wr_reg(ADDR_CLOCK_CONTROL, 8'h00);
        wr_reg(ADDR_COUNT_LOW, 8'h00);
        wr_reg(ADDR_COUNT_HIGH, 8'h00);
        wr_reg(ADDR_TIMER_CONTROL, 8'h04);
        idle(120);
        wr_reg(ADDR_TIMER_CONTROL, 8'h00);
        rd_in("sys over 12", ADDR_COUNT_LOW, 8'h0A, 8'h0B);
        rd_eq("sys over 12 high", ADDR_COUNT_HIGH, 8'h00);
        // External source: nothing without edges, then 32 slow toggles
        wr_reg(ADDR_COUNT_LOW, 8'h00);
        wr_reg(ADDR_TIMER_CONTROL, 8'h05);
        idle(40);
        rd_eq("ext idle", ADDR_COUNT_LOW, 8'h00);
        // Four cycles per level leaves the synchroniser time to see each edge
        repeat (32) begin
            idle(4);
            ext_osc <= ~ext_osc;
        end
        idle(8);
        wr_reg(ADDR_TIMER_CONTROL, 8'h00);
        rd_in("ext over 8", ADDR_COUNT_LOW, 8'h02, 8'h04);
        // Clock enable low for 20 edges: only the two enabled edges advance the count
        wr_reg(ADDR_CLOCK_CONTROL, 8'h03);
        wr_reg(ADDR_COUNT_LOW, 8'h00);
        wr_reg(ADDR_TIMER_CONTROL, 8'h04);
        clk_en <= 1'b0;
        idle(20);
        clk_en <= 1'b1;
        wr_reg(ADDR_TIMER_CONTROL, 8'h00);
        rd_eq("frozen count", ADDR_COUNT_LOW, 8'h02);
        wrap_up();
    end
endmodule
`default_nettype wire
